// *** lhp_dev.sv ***
// device end: register access port with alarm interrupt
`timescale 1ns/1ps
`default_nettype none
`include "lhp_cfg.svh"
module lhp_dev (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // pins
    lhp_if.dev              pins,
    // alarm events from the line side
    input  wire logic [7:0] i_alarm_evt,
    // register write notification
    output logic            o_wr_stb,
    output logic      [7:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    // mode in use
    output logic            o_sync_mode
);
    logic [7:0]  s_addr;
    logic [7:0]  s_d;
    logic [5:0]  s_ctl;
    logic        s_cs_n;
    logic        s_rd_n;
    logic        s_wr_n;
    logic        s_pmode;
    logic        s_pclk;
    logic        s_rst_n;
    logic        pclk_d_r;
    logic        en;
    logic        rst;
    logic        cmd_rd;
    logic        cmd_wr;
    logic        alarm_clr;
    logic [7:0]  alarm_r;
    logic [7:0]  alarm_nxt;
    logic [7:0]  rdata_r;
    logic        oe_r;
    logic        rdy_n_r;
    logic        int_n_r;
    logic [7:0]  regs [0:255];
    lhp_pkg::lhp_dev_st_t st_r;

    // every pin passes two flops
    lhp_sync #(.W(8)) u_sa (.i_clk(i_clk), .i_d(pins.addr),  .o_q(s_addr));
    lhp_sync #(.W(8)) u_sd (.i_clk(i_clk), .i_d(pins.bus_d), .o_q(s_d));
    lhp_sync #(.W(6)) u_sc (
        .i_clk (i_clk),
        .i_d   ({pins.cs_n, pins.rd_n, pins.wr_n, pins.pmode, pins.pclk, pins.rst_n}),
        .o_q   (s_ctl)
    );
    assign {s_cs_n, s_rd_n, s_wr_n, s_pmode, s_pclk, s_rst_n} = s_ctl;

    // reset from port or pin
    assign rst = i_srst | ~s_rst_n;

    // host clock rising edge paces sampling in sync mode
    always_ff @(posedge i_clk) begin
        pclk_d_r <= s_pclk;
    end
    assign en = s_pmode ? (s_pclk & ~pclk_d_r) : 1'b1;

    // command decode, select must be low
    assign cmd_rd = en & ~s_cs_n & ~s_rd_n & s_wr_n;
    assign cmd_wr = en & ~s_cs_n & ~s_wr_n & s_rd_n;
    assign alarm_clr = (st_r == lhp_pkg::DV_IDLE) && cmd_rd && (s_addr == `LHP_ALARM_ADDR);

    // access sequencer
    always_ff @(posedge i_clk) begin
        if (rst) begin
            st_r    <= lhp_pkg::DV_IDLE;
            rdy_n_r <= 1'b1;
            oe_r    <= 1'b0;
        end else begin
            case (st_r)
                lhp_pkg::DV_IDLE: begin
                    if (cmd_rd) begin
                        oe_r    <= 1'b1;
                        rdy_n_r <= 1'b0;
                        st_r    <= lhp_pkg::DV_DONE;
                    end else if (cmd_wr) begin
                        rdy_n_r <= 1'b0;
                        st_r    <= lhp_pkg::DV_DONE;
                    end
                end
                lhp_pkg::DV_DONE: begin
                    if (s_cs_n) begin
                        rdy_n_r <= 1'b1;
                        oe_r    <= 1'b0;
                        st_r    <= lhp_pkg::DV_IDLE;
                    end else if (en && s_rd_n && s_wr_n) begin
                        rdy_n_r <= 1'b1;
                        oe_r    <= 1'b0;
                        st_r    <= lhp_pkg::DV_WCS;
                    end
                end
                lhp_pkg::DV_WCS: begin
                    if (s_cs_n) begin
                        st_r <= lhp_pkg::DV_IDLE;
                    end
                end
                default: begin
                    st_r <= lhp_pkg::DV_IDLE;
                end
            endcase
        end
    end

    // read data, loaded with the drivers so it is valid with done
    always_ff @(posedge i_clk) begin
        if (rst) begin
            rdata_r <= `LHP_REG_RST;
        end else if ((st_r == lhp_pkg::DV_IDLE) && cmd_rd) begin
            rdata_r <= (s_addr == `LHP_ALARM_ADDR) ? alarm_r : regs[s_addr];
        end
    end

    // register store, data captured on write strobe
    always_ff @(posedge i_clk) begin
        if (!rst && (st_r == lhp_pkg::DV_IDLE) && cmd_wr) begin
            regs[s_addr] <= s_d;
        end
    end

    // write notification to the line side
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_wr_stb  <= 1'b0;
            o_wr_addr <= 8'h00;
            o_wr_data <= 8'h00;
        end else begin
            o_wr_stb <= (st_r == lhp_pkg::DV_IDLE) && cmd_wr;
            if ((st_r == lhp_pkg::DV_IDLE) && cmd_wr) begin
                o_wr_addr <= s_addr;
                o_wr_data <= s_d;
            end
        end
    end

    // sticky alarms, a new event beats the read clear
    assign alarm_nxt = (alarm_clr ? 8'h00 : alarm_r) | i_alarm_evt;
    always_ff @(posedge i_clk) begin
        if (rst) begin
            alarm_r <= 8'h00;
            int_n_r <= 1'b1;
        end else begin
            alarm_r <= alarm_nxt;
            int_n_r <= ~(|alarm_nxt);
        end
    end

    // mode report
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_sync_mode <= 1'b0;
        end else begin
            o_sync_mode <= s_pmode;
        end
    end

    assign pins.rdy_n    = rdy_n_r;
    assign pins.int_n    = int_n_r;
    assign pins.dev_d    = rdata_r;
    assign pins.dev_d_oe = oe_r;
endmodule : lhp_dev
`default_nettype wire

// *** lhp_cfg.svh ***
// constants and timing counts of the parallel host port
// What this block does
// - timing select low async, high sync
// - sync mode: host clock times every cycle
// - eight-bit two-way data bus
// - eight-bit direct address picks register
// - accesses taken only while select low
// - read strobe low with select: read
// - write strobe low with select: write
// - cycle-done low marks finished cycle
// - alarm change pulls interrupt, read clears
// - reset pin low resets the logic; the register store keeps its contents
// - host sets address with select low
// - read strobe enables data drivers
// - cycle-done low once read data valid
// - host ends read after done, data
// - host raises select after each access
// - host drives write data before strobe
// - write strobe enables data capture path
// - cycle-done low once write data stored
`ifndef LHP_CFG_SVH
`define LHP_CFG_SVH
`define LHP_CLK_MHZ       40
`define LHP_STRB_MIN_NS   70
`define LHP_STRB_MIN_CYC  ((`LHP_STRB_MIN_NS * `LHP_CLK_MHZ + 999) / 1000)
`define LHP_RDY_MAX_NS    65
`define LHP_RDY_MAX_CYC   ((`LHP_RDY_MAX_NS * `LHP_CLK_MHZ) / 1000)
`define LHP_PCLK_HALF     4'h1
`define LHP_ALARM_ADDR    8'h03
`define LHP_REG_RST       8'h00
`define LHP_BUS_IDLE      8'hFF
`endif

// *** lhp_pkg.sv ***
// types shared by both ends of the parallel host port
`default_nettype none
package lhp_pkg;
    typedef enum logic [1:0] {
        DV_IDLE = 2'b00,
        DV_DONE = 2'b01,
        DV_WCS  = 2'b10
    } lhp_dev_st_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_SETUP = 3'b001,
        HS_STRB  = 3'b010,
        HS_END   = 3'b011,
        HS_CSHI  = 3'b100
    } lhp_host_st_t;
endpackage : lhp_pkg
`default_nettype wire

// *** lhp_if.sv ***
// pin bundle joining host and device ends
`timescale 1ns/1ps
`default_nettype none
`include "lhp_cfg.svh"
interface lhp_if;
    logic       pmode;
    logic       pclk;
    logic       rst_n;
    logic [7:0] addr;
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic       rdy_n;
    logic       int_n;
    logic [7:0] host_d;
    logic       host_d_oe;
    logic [7:0] dev_d;
    logic       dev_d_oe;
    wire  [7:0] bus_d;

    // resolved data bus level, pulled high when nobody drives
    assign bus_d = dev_d_oe ? dev_d : (host_d_oe ? host_d : `LHP_BUS_IDLE);

    modport dev (
        input  pmode, pclk, rst_n, addr, cs_n, rd_n, wr_n, bus_d,
        output rdy_n, int_n, dev_d, dev_d_oe
    );
    modport host (
        input  rdy_n, int_n, bus_d,
        output pmode, pclk, rst_n, addr, cs_n, rd_n, wr_n, host_d, host_d_oe
    );
endinterface : lhp_if
`default_nettype wire

// *** lhp_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module lhp_sync #(
    parameter int W = 1
) (
    // clock
    input  wire logic         i_clk,
    // pin side
    input  wire logic [W-1:0] i_d,
    // clock side
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;

    // first stage read only by the second
    always_ff @(posedge i_clk) begin
        meta_r <= i_d;
        o_q    <= meta_r;
    end
endmodule : lhp_sync
`default_nettype wire

// *** lhp_host.sv ***
// host end: drives accesses onto the parallel host port
`timescale 1ns/1ps
`default_nettype none
`include "lhp_cfg.svh"
module lhp_host (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // pins
    lhp_if.host             pins,
    // mode choice
    input  wire logic       i_sync_mode,
    // access request
    input  wire logic       i_req,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    // access answer
    output logic            o_busy,
    output logic            o_done,
    output logic      [7:0] o_rdata,
    output logic            o_irq
);
    logic [9:0]  s_in;
    logic [7:0]  s_d;
    logic        s_rdy_n;
    logic        s_int_n;
    logic [3:0]  div_r;
    logic        pclk_r;
    logic        pmode_r;
    logic        rst_n_r;
    logic [7:0]  addr_r;
    logic [7:0]  hd_r;
    logic        hd_oe_r;
    logic        cs_n_r;
    logic        rd_n_r;
    logic        wr_n_r;
    logic        wr_r;
    logic [3:0]  cnt_r;
    lhp_pkg::lhp_host_st_t st_r;

    // device pins pass two flops
    lhp_sync #(.W(10)) u_si (
        .i_clk (i_clk),
        .i_d   ({pins.bus_d, pins.rdy_n, pins.int_n}),
        .o_q   (s_in)
    );
    assign {s_d, s_rdy_n, s_int_n} = s_in;

    // mode pin, reset pin and host clock divider
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rst_n_r <= 1'b0;
            pmode_r <= 1'b0;
            pclk_r  <= 1'b0;
            div_r   <= 4'h0;
        end else begin
            rst_n_r <= 1'b1;
            pmode_r <= i_sync_mode;
            if (div_r == `LHP_PCLK_HALF) begin
                div_r  <= 4'h0;
                pclk_r <= ~pclk_r & pmode_r;
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    // access sequencer
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_r    <= lhp_pkg::HS_IDLE;
            cs_n_r  <= 1'b1;
            rd_n_r  <= 1'b1;
            wr_n_r  <= 1'b1;
            hd_oe_r <= 1'b0;
            addr_r  <= 8'h00;
            hd_r    <= 8'h00;
            wr_r    <= 1'b0;
            cnt_r   <= 4'h0;
            o_done  <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_done <= 1'b0;
            case (st_r)
                lhp_pkg::HS_IDLE: begin
                    if (i_req && rst_n_r) begin
                        addr_r  <= i_addr;
                        cs_n_r  <= 1'b0;
                        wr_r    <= i_wr;
                        hd_r    <= i_wdata;
                        hd_oe_r <= i_wr;
                        st_r    <= lhp_pkg::HS_SETUP;
                    end
                end
                lhp_pkg::HS_SETUP: begin
                    rd_n_r <= wr_r;
                    wr_n_r <= ~wr_r;
                    cnt_r  <= 4'h0;
                    st_r   <= lhp_pkg::HS_STRB;
                end
                lhp_pkg::HS_STRB: begin
                    if (cnt_r != 4'hF) begin
                        cnt_r <= cnt_r + 4'h1;
                    end
                    if (!s_rdy_n && (cnt_r >= 4'(`LHP_STRB_MIN_CYC))) begin
                        o_rdata <= s_d;
                        rd_n_r  <= 1'b1;
                        wr_n_r  <= 1'b1;
                        st_r    <= lhp_pkg::HS_END;
                    end
                end
                lhp_pkg::HS_END: begin
                    if (s_rdy_n) begin
                        cs_n_r  <= 1'b1;
                        hd_oe_r <= 1'b0;
                        o_done  <= 1'b1;
                        st_r    <= lhp_pkg::HS_CSHI;
                    end
                end
                lhp_pkg::HS_CSHI: begin
                    st_r <= lhp_pkg::HS_IDLE;
                end
                default: begin
                    st_r <= lhp_pkg::HS_IDLE;
                end
            endcase
        end
    end

    // status to the user
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_busy <= 1'b1;
            o_irq  <= 1'b0;
        end else begin
            o_busy <= (st_r != lhp_pkg::HS_IDLE) || (i_req && rst_n_r) || !rst_n_r;
            o_irq  <= ~s_int_n;
        end
    end

    assign pins.pmode     = pmode_r;
    assign pins.pclk      = pclk_r;
    assign pins.rst_n     = rst_n_r;
    assign pins.addr      = addr_r;
    assign pins.cs_n      = cs_n_r;
    assign pins.rd_n      = rd_n_r;
    assign pins.wr_n      = wr_n_r;
    assign pins.host_d    = hd_r;
    assign pins.host_d_oe = hd_oe_r;
endmodule : lhp_host
`default_nettype wire

// *** lhp_monitor.sv ***
// pin-level checks on the host port link
`timescale 1ns/1ps
`default_nettype none
`include "lhp_cfg.svh"
module lhp_monitor (
    // clock and reset
    input wire logic       i_clk,
    input wire logic       i_srst,
    // link pins
    input wire logic       pmode,
    input wire logic [7:0] addr,
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       rdy_n,
    input wire logic       int_n,
    input wire logic [7:0] host_d,
    input wire logic       host_d_oe,
    input wire logic       dev_d_oe
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);

    // data drivers and ready answer
    a_drv_in_read: assert property (dev_d_oe |-> !cs_n && wr_n)
        else $error("device drives bus outside a read");
    a_no_bus_fight: assert property (!(dev_d_oe && host_d_oe))
        else $error("both ends drive the bus");
    a_oe_with_rdy: assert property ($rose(dev_d_oe) |-> $fell(rdy_n))
        else $error("drivers on without ready");
    a_rdy_cause: assert property ($fell(rdy_n) |-> !cs_n && (rd_n != wr_n))
        else $error("ready without selected strobe");
    a_rd_data_valid: assert property ($fell(rdy_n) && !rd_n |-> dev_d_oe)
        else $error("read ready without data");
    a_rd_answer: assert property ($fell(rd_n) && !cs_n && !pmode |-> ##[1:6] !rdy_n)
        else $error("read not answered");
    a_wr_answer: assert property ($fell(wr_n) && !cs_n && !pmode |-> ##[1:6] !rdy_n)
        else $error("write not answered");
    a_rdy_stands: assert property (!rdy_n && !(rd_n && wr_n) |=> !rdy_n)
        else $error("ready dropped under strobe");
    // interrupt release and host ordering
    a_int_read_clr: assert property ($rose(int_n) |->
        !$past(cs_n) && !$past(rd_n) && ($past(addr) == `LHP_ALARM_ADDR))
        else $error("interrupt released without status read");
    a_sel_fresh: assert property ($fell(cs_n) |-> rd_n && wr_n)
        else $error("select fell with strobe low");
    a_wr_data_first: assert property ($fell(wr_n) |-> host_d_oe && $stable(host_d))
        else $error("write data not ahead of strobe");

    a_addr_held: assert property (!cs_n && !$past(cs_n) |-> $stable(addr))
        else $error("address moved while selected");
    a_rd_end_late: assert property ($rose(rd_n) |-> !$past(rdy_n))
        else $error("read ended before ready");
    a_wr_no_drive: assert property (!rdy_n && !wr_n |-> !dev_d_oe)
        else $error("device drives bus in a write");

    c_read: cover property ($fell(rdy_n) && !rd_n);
    c_write: cover property ($fell(rdy_n) && !wr_n);
    c_sync: cover property ($fell(rdy_n) && pmode);
    c_irq: cover property ($fell(int_n));
endmodule : lhp_monitor
`default_nettype wire

// *** tb_lineif_parallel_host_port.sv ***
// self-checking bench joining host and device ends
`timescale 1ns/1ps
`default_nettype none
module tb_lineif_parallel_host_port;
    logic       clk       = 1'b0;
    logic       srst      = 1'b1;
    logic       sync_mode = 1'b0;
    logic       req       = 1'b0;
    logic       wr        = 1'b0;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic [7:0] alarm_evt = 8'h00;
    logic       busy, done, irq, wr_stb, dev_sync;
    logic [7:0] host_rdata, wr_addr, wr_data, rdata, cap_addr, cap_data;
    int         fail_count = 0;
    int         tests_run  = 0;

    lhp_if i_lhp_if ();
    lhp_if i_lhp_if_b ();
    lhp_host i_lhp_host (.i_clk(clk), .i_srst(srst), .pins(i_lhp_if), .i_sync_mode(sync_mode),
        .i_req(req), .i_wr(wr), .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
        .o_rdata(host_rdata), .o_irq(irq));
    lhp_dev i_lhp_dev (.i_clk(clk), .i_srst(srst), .pins(i_lhp_if), .i_alarm_evt(alarm_evt),
        .o_wr_stb(wr_stb), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_sync_mode(dev_sync));
    lhp_dev i_lhp_dev_b (.i_clk(clk), .i_srst(srst), .pins(i_lhp_if_b), .i_alarm_evt(8'h00),
        .o_wr_stb(), .o_wr_addr(), .o_wr_data(), .o_sync_mode());
    lhp_monitor i_lhp_monitor (.i_clk(clk), .i_srst(srst), .pmode(i_lhp_if.pmode),
        .addr(i_lhp_if.addr), .cs_n(i_lhp_if.cs_n), .rd_n(i_lhp_if.rd_n),
        .wr_n(i_lhp_if.wr_n), .rdy_n(i_lhp_if.rdy_n), .int_n(i_lhp_if.int_n),
        .host_d(i_lhp_if.host_d), .host_d_oe(i_lhp_if.host_d_oe),
        .dev_d_oe(i_lhp_if.dev_d_oe));

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // last write reported by the device
    always @(posedge clk) begin
        if (wr_stb === 1'b1) begin
            cap_addr <= wr_addr;
            cap_data <= wr_data;
        end
    end

    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        chk8(what, {7'h00, exp}, {7'h00, got});
    endtask : chk1

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // one host access through the host end
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        for (n = 0; n < 50 && busy !== 1'b0; n++) tick();
        if (n == 50) begin
            chk1("access idle", 1'b0, busy);
            tally_and_finish();
        end
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        for (n = 0; n < 50 && busy !== 1'b1; n++) tick();
        if (n == 50) begin
            chk1("access taken", 1'b1, busy);
            tally_and_finish();
        end
        req = 1'b0;
        for (n = 0; n < 80 && done !== 1'b1; n++) tick();
        if (n == 80) begin
            chk1("access done", 1'b1, 1'b0);
            tally_and_finish();
        end
        rdata = host_rdata;
    endtask : access

    task automatic s_rw(input logic s, input logic [7:0] d1, input logic [7:0] d2);
        sync_mode = s;
        access(1'b1, 8'h10, d1);
        chk8("write addr", 8'h10, cap_addr);
        chk8("write data", d1, cap_data);
        access(1'b1, 8'hFF, d2);
        access(1'b0, 8'h10, 8'h00);
        chk8("read 10", d1, rdata);
        access(1'b0, 8'hFF, 8'h00);
        chk8("read FF", d2, rdata);
        chk1("sync mode", s, dev_sync);
    endtask : s_rw

    task automatic s_alarm();
        int n;
        alarm_evt = 8'h24;
        tick();
        alarm_evt = 8'h00;
        for (n = 0; n < 10 && irq !== 1'b1; n++) tick();
        chk1("irq raised", 1'b1, irq);
        access(1'b0, 8'h03, 8'h00);
        chk8("alarm status", 8'h24, rdata);
        for (n = 0; n < 10 && irq !== 1'b0; n++) tick();
        chk1("irq cleared", 1'b0, irq);
        access(1'b0, 8'h03, 8'h00);
        chk8("alarm reread", 8'h00, rdata);
    endtask : s_alarm

    // second link: bench plays a careless host
    task automatic s_refuse();
        int n;
        i_lhp_if_b.rd_n = 1'b0;
        repeat (10) tick();
        chk1("unselected rdy", 1'b1, i_lhp_if_b.rdy_n);
        chk1("unselected oe", 1'b0, i_lhp_if_b.dev_d_oe);
        i_lhp_if_b.cs_n = 1'b0;
        i_lhp_if_b.wr_n = 1'b0;
        repeat (10) tick();
        chk1("two strobes rdy", 1'b1, i_lhp_if_b.rdy_n);
        i_lhp_if_b.rd_n = 1'b1;
        i_lhp_if_b.wr_n = 1'b1;
        i_lhp_if_b.cs_n = 1'b1;
        repeat (4) tick();
        i_lhp_if_b.cs_n = 1'b0;
        i_lhp_if_b.host_d_oe = 1'b1;
        i_lhp_if_b.host_d = 8'h77;
        tick();
        i_lhp_if_b.wr_n = 1'b0;
        for (n = 0; n < 8 && i_lhp_if_b.rdy_n !== 1'b0; n++) tick();
        chk1("write rdy", 1'b0, i_lhp_if_b.rdy_n);
        chk1("write oe", 1'b0, i_lhp_if_b.dev_d_oe);
        i_lhp_if_b.wr_n = 1'b1;
        for (n = 0; n < 8 && i_lhp_if_b.rdy_n !== 1'b1; n++) tick();
        i_lhp_if_b.cs_n = 1'b1;
        i_lhp_if_b.host_d_oe = 1'b0;
        repeat (4) tick();
        i_lhp_if_b.cs_n = 1'b0;
        tick();
        i_lhp_if_b.rd_n = 1'b0;
        for (n = 0; n < 8 && i_lhp_if_b.rdy_n !== 1'b0; n++) tick();
        chk1("read oe", 1'b1, i_lhp_if_b.dev_d_oe);
        chk8("read back 77", 8'h77, i_lhp_if_b.bus_d);
        i_lhp_if_b.rd_n = 1'b1;
        for (n = 0; n < 8 && i_lhp_if_b.rdy_n !== 1'b1; n++) tick();
        chk1("read oe off", 1'b0, i_lhp_if_b.dev_d_oe);
        i_lhp_if_b.cs_n = 1'b1;
    endtask : s_refuse

    task automatic s_reset();
        alarm_evt = 8'h81;
        tick();
        alarm_evt = 8'h00;
        srst = 1'b1;
        repeat (3) tick();
        chk1("int in reset", 1'b1, i_lhp_if.int_n);
        srst = 1'b0;
        access(1'b0, 8'h03, 8'h00);
        chk8("alarm after reset", 8'h00, rdata);
    endtask : s_reset

    // main sequence
    initial begin
        i_lhp_if_b.pmode = 1'b0;
        i_lhp_if_b.pclk = 1'b0;
        i_lhp_if_b.rst_n = 1'b1;
        i_lhp_if_b.addr = 8'h10;
        i_lhp_if_b.cs_n = 1'b1;
        i_lhp_if_b.rd_n = 1'b1;
        i_lhp_if_b.wr_n = 1'b1;
        i_lhp_if_b.host_d = 8'h00;
        i_lhp_if_b.host_d_oe = 1'b0;
        repeat (5) tick();
        srst = 1'b0;
        chk1("rdy idle", 1'b1, i_lhp_if.rdy_n);
        s_rw(1'b0, 8'h5A, 8'hA5);
        s_rw(1'b1, 8'hC3, 8'h3C);
        sync_mode = 1'b0;
        s_alarm();
        s_refuse();
        s_reset();
        tally_and_finish();
    end
endmodule : tb_lineif_parallel_host_port
`default_nettype wire
